//--- iodc_pkg.sv
package iodc_pkg;

    // Register placement on the host bus
    localparam int          ADDR_W           = 8;
    localparam logic [7:0]  CFG_OFFSET       = 8'h54;

    // Field positions inside the configuration word
    localparam int          HOLDOFF_W        = 8;
    localparam int          HOLDOFF_LSB      = 24;
    localparam int          RESTART_BIT      = 14;
    localparam int          ACTIVE_BIT       = 13;
    localparam int          MASTER_BIT       = 12;
    localparam int          ENABLE_BIT       = 8;
    localparam int          POLARITY_BIT     = 4;
    localparam int          BUF_TYPE_BIT     = 0;

    // Values after reset
    localparam logic [7:0]  HOLDOFF_RESET    = 8'h00;
    localparam logic        ENABLE_RESET     = 1'b0;
    localparam logic        POLARITY_RESET   = 1'b0;
    localparam logic        BUF_TYPE_RESET   = 1'b0;
    localparam logic [31:0] RDATA_RESET      = 32'h0000_0000;

    // Hold-off timebase
    localparam int          CLOCK_PERIOD_NS  = 100;
    localparam int          HOLDOFF_UNIT_US  = 10;
    localparam int          HOLDOFF_UNIT_CYCLES = (HOLDOFF_UNIT_US * 1000) / CLOCK_PERIOD_NS;

endpackage : iodc_pkg

//--- iodc_holdoff_timer.sv
`timescale 1ns/1ns
`default_nettype none

module iodc_holdoff_timer
    import iodc_pkg::*;
#(
    parameter int UNIT_CYCLES = HOLDOFF_UNIT_CYCLES
) (
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 start,
    input  wire logic                 stop,
    input  wire logic [HOLDOFF_W-1:0] interval,
    output logic                      active
);

    localparam int PW = $clog2(UNIT_CYCLES + 1);

    typedef struct packed {
        logic [PW-1:0]        prescale;
        logic [HOLDOFF_W-1:0] units;
        logic                 active;
    } iodc_timer_type;

    iodc_timer_type s_q;
    iodc_timer_type s_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Interval counting: prescaler makes 10 us units, units run up to the interval
    always_comb begin
        s_d = s_q;
        if (stop) begin
            s_d.prescale = '0;
            s_d.units    = '0;
            s_d.active   = 1'b0;
        end else if (start) begin
            s_d.prescale = '0;
            s_d.units    = '0;
            s_d.active   = 1'b1;
        end else if (s_q.active) begin
            if (s_q.prescale == PW'(UNIT_CYCLES - 1)) begin
                s_d.prescale = '0;
                if (s_q.units + 8'h01 >= interval) begin
                    s_d.units  = '0;
                    s_d.active = 1'b0;
                end else begin
                    s_d.units = s_q.units + 8'h01;
                end
            end else begin
                s_d.prescale = s_q.prescale + PW'(1);
            end
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign active = s_q.active;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [15:0] tally_q;

    // Counts active cycles since the last start
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tally_q <= 16'h0000;
        end else if (start) begin
            tally_q <= 16'h0000;
        end else if (s_q.active) begin
            tally_q <= tally_q + 16'h0001;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_INTERVAL_LENGTH: assert property (
        $fell(s_q.active) && !$past(stop) && $stable(interval)
        |-> tally_q == 16'(interval * UNIT_CYCLES))
        else $error("Hold-off interval length wrong");

endmodule : iodc_holdoff_timer

`default_nettype wire

//--- iodc_irq_output.sv
`timescale 1ns/1ns
`default_nettype none


module iodc_irq_output
    import iodc_pkg::*;
#(
    parameter int UNIT_CYCLES = HOLDOFF_UNIT_CYCLES
) (
    input  wire logic              clock,
    input  wire logic              resetn,
    input  wire logic              soft_reset,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [31:0]       reg_wdata,
    output logic      [31:0]       reg_rdata,
    output logic                   reg_rvalid,
    input  wire logic              irq_internal,
    input  wire logic              power_event_irq,
    output logic                   irq_pin_o,
    output logic                   irq_pin_oe
);

    typedef struct packed {
        logic [HOLDOFF_W-1:0] holdoff_interval;
        logic                 irq_enable;
        logic                 irq_output_polarity;
        logic                 buf_push_pull;
        logic                 holdoff_restart;
        logic                 pin_active;
        logic                 irq_o;
        logic                 irq_oe;
        logic [31:0]          rdata;
        logic                 rvalid;
    } iodc_state_type;

    iodc_state_type s_q;
    iodc_state_type s_d;

    logic rst_meta_q;
    logic rst_n_q;
    logic holdoff_active;
    logic cfg_hit;
    logic deliver;
    logic timer_start;
    logic timer_stop;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Delivery and interval control
    assign cfg_hit = (reg_addr == CFG_OFFSET);

    assign deliver = s_q.irq_enable
                     & ((irq_internal & ~holdoff_active) | power_event_irq);

    assign timer_start = s_q.holdoff_restart | (s_q.pin_active & ~deliver);

    assign timer_stop = (s_q.holdoff_interval == HOLDOFF_RESET);

    iodc_holdoff_timer #(
        .UNIT_CYCLES (UNIT_CYCLES)
    ) u_timer (
        .clock    (clock),
        .rst_n    (rst_n_q),
        .start    (timer_start),
        .stop     (timer_stop),
        .interval (s_q.holdoff_interval),
        .active   (holdoff_active)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next state: register writes, reads and pin drive
    always_comb begin
        s_d                 = s_q;
        s_d.holdoff_restart = 1'b0;
        s_d.rvalid          = reg_rd;
        s_d.rdata           = RDATA_RESET;
        if (reg_wr && cfg_hit) begin
            s_d.holdoff_interval    = reg_wdata[HOLDOFF_LSB +: HOLDOFF_W];
            s_d.irq_enable          = reg_wdata[ENABLE_BIT];
            s_d.irq_output_polarity = reg_wdata[POLARITY_BIT];
            s_d.buf_push_pull       = reg_wdata[BUF_TYPE_BIT];
            s_d.holdoff_restart     = reg_wdata[RESTART_BIT];
        end
        // Soft reset leaves polarity and buffer type alone
        if (soft_reset) begin
            s_d.holdoff_interval = HOLDOFF_RESET;
            s_d.irq_enable       = ENABLE_RESET;
            s_d.holdoff_restart  = 1'b0;
        end
        if (reg_rd && cfg_hit) begin
            s_d.rdata[HOLDOFF_LSB +: HOLDOFF_W] = s_q.holdoff_interval;
            s_d.rdata[ACTIVE_BIT]   = holdoff_active;
            s_d.rdata[MASTER_BIT]   = irq_internal;
            s_d.rdata[ENABLE_BIT]   = s_q.irq_enable;
            s_d.rdata[POLARITY_BIT] = s_q.irq_output_polarity;
            s_d.rdata[BUF_TYPE_BIT] = s_q.buf_push_pull;
        end
        s_d.pin_active = deliver;
        if (s_q.buf_push_pull) begin
            s_d.irq_oe = 1'b1;
            s_d.irq_o  = s_q.irq_output_polarity ~^ deliver;
        end else begin
            s_d.irq_oe = deliver;
            s_d.irq_o  = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            s_q.holdoff_interval    <= HOLDOFF_RESET;
            s_q.irq_enable          <= ENABLE_RESET;
            s_q.irq_output_polarity <= POLARITY_RESET;
            s_q.buf_push_pull       <= BUF_TYPE_RESET;
            s_q.holdoff_restart     <= 1'b0;
            s_q.pin_active          <= 1'b0;
            s_q.irq_o               <= 1'b0;
            s_q.irq_oe              <= 1'b0;
            s_q.rdata               <= RDATA_RESET;
            s_q.rvalid              <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata  = s_q.rdata;
    assign reg_rvalid = s_q.rvalid;
    assign irq_pin_o  = s_q.irq_o;
    assign irq_pin_oe = s_q.irq_oe;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n_q);

    AST_ZERO_DISABLES: assert property (
        timer_stop |=> !holdoff_active)
        else $error("Interval still active with zero hold-off");

    AST_ZERO_PASSES: assert property (
        $past(timer_stop) && timer_stop && s_q.irq_enable && irq_internal |=> s_q.pin_active)
        else $error("Pending interrupt not issued with zero hold-off");

    AST_NEW_VALUE: assert property (
        s_q.holdoff_restart && !timer_stop |=> holdoff_active)
        else $error("Restart with non-zero value did not start interval");

    AST_POWER_BYPASS: assert property (
        s_q.irq_enable && power_event_irq |=> s_q.pin_active)
        else $error("Power event held off");

    AST_RESTART_PULSE: assert property (
        reg_wr && cfg_hit && reg_wdata[RESTART_BIT] && !soft_reset
        |=> s_q.holdoff_restart ##1 !s_q.holdoff_restart)
        else $error("Restart bit not a single pulse");

    AST_HOLDOFF_BLOCKS: assert property (
        holdoff_active && !power_event_irq |=> !s_q.pin_active)
        else $error("Interrupt reached pin during interval");

    AST_MASTER_READ: assert property (
        reg_rd && cfg_hit |=> reg_rvalid && reg_rdata[MASTER_BIT] == $past(irq_internal))
        else $error("Master bit does not follow internal line");

    AST_DISABLED_PIN: assert property (
        !s_q.irq_enable |=> !s_q.pin_active)
        else $error("Pin asserted while disabled");

    AST_PUSH_PULL: assert property (
        s_q.buf_push_pull
        |=> irq_pin_oe && irq_pin_o == ($past(s_q.irq_output_polarity) ~^ s_q.pin_active))
        else $error("Push-pull level wrong");

    AST_OPEN_DRAIN: assert property (
        !s_q.buf_push_pull |=> !irq_pin_o && irq_pin_oe == s_q.pin_active)
        else $error("Open-drain drive wrong");

    AST_FALL_STARTS: assert property (
        $fell(s_q.pin_active) && !$past(timer_stop) |-> holdoff_active)
        else $error("Deassertion did not start interval");

    COV_INTERVAL_RUN: cover property ($rose(holdoff_active) ##[1:1000] $fell(holdoff_active));
    COV_RESTART: cover property (s_q.holdoff_restart && holdoff_active);
    COV_PUSH_PULL_HIGH: cover property (s_q.buf_push_pull && s_q.irq_output_polarity && irq_pin_o);
    COV_POWER_DURING: cover property (holdoff_active && power_event_irq ##1 s_q.pin_active);

endmodule : iodc_irq_output

`default_nettype wire

//--- iodc_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module iodc_host_model
    import iodc_pkg::*;
(
    input  wire logic pin_o,
    input  wire logic pin_oe,
    input  wire logic active_high,
    output logic      irq_wire,
    output logic      irq_seen
);
    // Pull-up holds the shared line high while nobody drives it
    assign irq_wire = pin_oe ? pin_o : 1'b1;
    // Host decodes the level it was told is active
    assign irq_seen = (irq_wire == active_high);
endmodule : iodc_host_model

`default_nettype wire

//--- test_irq_output_deassert_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

module test_irq_output_deassert_ctrl import iodc_pkg::*; ();
    localparam int U = 5;
    logic        clock;
    logic        resetn;
    logic        soft_reset;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic        reg_rvalid;
    logic        irq_internal;
    logic        power_event_irq;
    logic        irq_pin_o;
    logic        irq_pin_oe;
    logic        irq_wire;
    logic        irq_seen;
    logic        pp;
    logic        pol;
    logic        en;
    logic [31:0] seed;
    logic [31:0] d;
    logic [7:0]  f;
    logic [7:0]  spans [4] = '{8'h01, 8'h00, 8'h00, 8'hFF};
    int          n;
    int          error_cnt;
    int          total_checks;

    iodc_irq_output #(.UNIT_CYCLES(U)) dut (
        .clock(clock), .resetn(resetn), .soft_reset(soft_reset),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .irq_internal(irq_internal), .power_event_irq(power_event_irq),
        .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe)
    );

    iodc_host_model host (
        .pin_o(irq_pin_o), .pin_oe(irq_pin_oe), .active_high(pp & pol),
        .irq_wire(irq_wire), .irq_seen(irq_seen)
    );

    // Free-running 10 MHz clock
    initial clock = 1'b0;
    always #50 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////
    // Expectation helpers
    function automatic logic [31:0] cfg(input logic [7:0] h, input logic e,
                                        input logic p, input logic b);
        cfg = (32'(h) << HOLDOFF_LSB) | (32'(e) << ENABLE_BIT)
            | (32'(p) << POLARITY_BIT) | (32'(b) << BUF_TYPE_BIT);
    endfunction : cfg

    // Open-drain only pulls low; push-pull always drives
    function automatic logic [1:0] pin_exp(input logic asr);
        if (!pp) begin
            pin_exp = asr ? 2'b10 : 2'b00;
        end else begin
            pin_exp = {1'b1, asr ? pol : ~pol};
        end
    endfunction : pin_exp

    // A span inside the latency window reads as the ideal figure
    function automatic logic [31:0] span_ok(input logic [7:0] h, input int cnt);
        int e;
        e = int'(h) * U;
        span_ok = (cnt >= e - 1 && cnt <= e + 4) ? 32'(e) : 32'(cnt);
    endfunction : span_ok

    ////////////////////////////////////////////////////////////////////////////
    // Bench tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Xorshift step for repeatable stimulus
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        xorshift = x ^ (x << 5);
    endfunction : xorshift

    task automatic setcfg(input logic [7:0] h, input logic e, input logic p,
                          input logic b, input logic rs);
        reg_addr = CFG_OFFSET;
        reg_wdata = cfg(h, e, p, b) | (32'(rs) << RESTART_BIT);
        reg_wr = 1'b1;
        {en, pol, pp} = {e, p, b};
        @(negedge clock);
        reg_wr = 1'b0;
        // Let an edge pass so a following strobe never rises in the same step
        @(negedge clock);
    endtask : setcfg

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        check("rvalid", 32'h1, {31'h0, reg_rvalid});
        v = reg_rdata;
        // Let an edge pass so a following strobe never rises in the same step
        @(negedge clock);
        check("rvalid low", 32'h0, {31'h0, reg_rvalid});
    endtask : rd

    // One-cycle dip of the internal line ends a delivery
    task automatic drop();
        irq_internal = 1'b0;
        @(negedge clock);
        irq_internal = 1'b1;
    endtask : drop

    task automatic wait_seen(output int cnt);
        cnt = 0;
        while (irq_seen !== 1'b1 && cnt < 3000) begin
            @(negedge clock);
            cnt++;
        end
    endtask : wait_seen

    task automatic conclude();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {soft_reset, reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
        {irq_internal, power_event_irq, pp, pol, en} = '0;
        resetn = 1'b0;
        seed = 32'd98;
        error_cnt = 0;
        total_checks = 0;
        repeat (2) @(negedge clock);
        resetn = 1'b1;
        repeat (3) @(negedge clock);
        rd(CFG_OFFSET, d);
        check("cfg reset", RDATA_RESET, d);
        rd(8'h58, d);
        check("unmapped", 32'h0, d);
        // Random pin modes with the hold-off off
        for (int i = 0; i < 24; i++) begin
            seed = xorshift(seed);
            setcfg(8'h00, seed[2], seed[1], seed[0], 1'b0);
            irq_internal = seed[3];
            repeat (2) @(negedge clock);
            check("pin", {30'h0, pin_exp(irq_internal & en)}, {30'h0, irq_pin_oe, irq_pin_o});
            check("host", {31'h0, irq_internal & en}, {31'h0, irq_seen});
            rd(CFG_OFFSET, d);
            check("cfg", cfg(8'h00, en, pol, pp) | (32'(irq_internal) << MASTER_BIT), d);
        end
        // Interval length for fixed, random and full-scale fields
        irq_internal = 1'b1;
        setcfg(8'h00, 1'b1, 1'b0, 1'b0, 1'b0);
        for (int k = 0; k < 4; k++) begin
            seed = xorshift(seed);
            f = (spans[k] != 8'h00) ? spans[k] : 8'(seed[2:0]) + 8'h01;
            setcfg(f, 1'b1, 1'b0, 1'b0, 1'b0);
            repeat (2) @(negedge clock);
            drop();
            wait_seen(n);
            check("span", 32'(f) * U, span_ok(f, n));
        end
        // Status, power event bypass, restart and zero field mid-interval
        setcfg(8'h04, 1'b1, 1'b0, 1'b0, 1'b0);
        drop();
        rd(CFG_OFFSET, d);
        check("active", cfg(8'h04, 1'b1, 1'b0, 1'b0) | (32'h1 << ACTIVE_BIT) | (32'h1 << MASTER_BIT), d);
        check("held", 32'h0, {31'h0, irq_seen});
        power_event_irq = 1'b1;
        repeat (2) @(negedge clock);
        check("power", 32'h1, {31'h0, irq_seen});
        power_event_irq = 1'b0;
        repeat (10) @(negedge clock);
        setcfg(8'h04, 1'b1, 1'b0, 1'b0, 1'b1);
        wait_seen(n);
        check("restart", 32'd4 * U, span_ok(8'h04, n));
        drop();
        setcfg(8'h00, 1'b1, 1'b0, 1'b0, 1'b0);
        repeat (2) @(negedge clock);
        check("zero", 32'h1, {31'h0, irq_seen});
        rd(CFG_OFFSET, d);
        check("idle", cfg(8'h00, 1'b1, 1'b0, 1'b0) | (32'h1 << MASTER_BIT), d);
        // Soft reset clears field and enable, keeps polarity and buffer type
        setcfg(8'h00, 1'b1, 1'b1, 1'b1, 1'b0);
        soft_reset = 1'b1;
        @(negedge clock);
        soft_reset = 1'b0;
        en = 1'b0;
        repeat (2) @(negedge clock);
        check("soft pin", {30'h0, pin_exp(1'b0)}, {30'h0, irq_pin_oe, irq_pin_o});
        rd(CFG_OFFSET, d);
        check("soft cfg", cfg(8'h00, 1'b0, 1'b1, 1'b1) | (32'h1 << MASTER_BIT), d);
        conclude();
    end

    // Watchdog well beyond the longest expected run
    initial begin
        #3_000_000;
        error_cnt++;
        conclude();
    end
endmodule : test_irq_output_deassert_ctrl

`default_nettype wire
